//--- rtl/usm_map.vh
`ifndef USM_MAP_VH
`define USM_MAP_VH
// ****************************************
// Register addresses on the internal bus
// ****************************************
`define USM_ADDR_MODE      16'hFF70
`define USM_ADDR_BAUD      16'hFF71
`define USM_ADDR_ERR       16'hFF73
`define USM_ADDR_RXBUF     16'hFF72
`define USM_ADDR_TXSHIFT   16'hFF74
// ****************************************
// Mode and error status register fields, and reset values
// ****************************************
`define USM_MODE_POWER     7
`define USM_MODE_TXEN      6
`define USM_MODE_RXEN      5
`define USM_MODE_PAR_HI    4
`define USM_MODE_PAR_LO    3
`define USM_MODE_CLEN      2
`define USM_MODE_STOP      1
`define USM_MODE_RESET     8'h01
`define USM_DATA_RESET     8'hFF
`define USM_BAUD_RESET     8'h1F
`define USM_ERR_PARITY     2
`define USM_ERR_FRAME      1
`define USM_ERR_OVERRUN    0
// ****************************************
// Parity modes
// ****************************************
`define USM_PAR_NONE       2'h0
`define USM_PAR_ZERO       2'h1
`define USM_PAR_ODD        2'h2
`define USM_PAR_EVEN       2'h3
`endif

//--- rtl/usm_baud_gen.v
`timescale 1ns/1ps
// ****************************************
// Baud tick generator: base clock prescale, 5-bit divider, then a half.
// ****************************************
module usm_baud_gen (
	input  wire       clk,       // System clock.
	input  wire       resetn,    // Synchronous reset, active low.
	input  wire       run,       // Power bit; low holds the dividers.
	input  wire [7:0] baud_cfg,  // Baud control register contents.
	output reg        base_tick, // One-cycle base clock pulse.
	output reg        div_tick,  // One-cycle 5-bit counter output pulse.
	output reg        half_tick  // Half of div_tick, the line bit rate.
);
	reg [4:0] pre_reg;   // Base clock prescaler.
	reg [4:0] cnt_reg;   // 5-bit divider counter.
	reg       half_reg;  // Toggles on each divider output.
	wire [4:0] pre_max;  // Prescaler terminal count.
	wire [4:0] div_max;  // Divider terminal count.

	// Base select: divide by 2, 8 or 32; code 0 also uses divide by 2.
	assign pre_max = (baud_cfg[7:6] == 2'h2) ? 5'h07 :
		(baud_cfg[7:6] == 2'h3) ? 5'h1F : 5'h01;
	// Codes below 8 are prohibited; they are clamped to 8 for safety.
	assign div_max = (baud_cfg[4:0] < 5'h08) ? 5'h07 : baud_cfg[4:0] - 5'h01;

	// Counters run only while powered, so the clock is stopped otherwise.
	always @(posedge clk) begin
		base_tick <= 1'b0;
		div_tick  <= 1'b0;
		half_tick <= 1'b0;
		if (!resetn || !run) begin
			pre_reg  <= 5'h00;
			cnt_reg  <= 5'h00;
			half_reg <= 1'b0;
		end else if (pre_reg >= pre_max) begin
			pre_reg   <= 5'h00;
			base_tick <= 1'b1;
			if (cnt_reg >= div_max) begin
				cnt_reg   <= 5'h00;
				div_tick  <= 1'b1;
				half_reg  <= ~half_reg;
				half_tick <= half_reg; // RULE24
			end else begin
				cnt_reg <= cnt_reg + 5'h01;
			end
		end else begin
			pre_reg <= pre_reg + 5'h01;
		end
	end
endmodule // usm_baud_gen

//--- rtl/usm_core.v
`timescale 1ns/1ps
// Function
// RULE1 - Completed character moves to receive buffer
// RULE2 - Seven-bit mode zeroes buffer bit seven
// RULE3 - Overrun keeps old buffer contents
// RULE4 - Buffer read-only, resets to all ones
// RULE5 - Shifter write starts transmission, write-only
// RULE6 - Shifter all ones on reset/disable
// RULE7 - Software waits one base clock first
// RULE8 - Software waits for transmit-complete pulse
// RULE9 - Mode register writable, resets to 01
// RULE10 - Power off stops clock, resets data
// RULE11 - Power off forces receive input high
// RULE12 - Transmit enable clear resets transmitter
// RULE13 - Receive enable clear resets receiver
// RULE14 - Parity field selects four parity modes
// RULE15 - Zero parity never flags parity error
// RULE16 - Length bit picks seven or eight
// RULE17 - Stop count bit gives one/two stops
// RULE18 - Receiver always uses one stop bit
// RULE19 - Software orders power and enable bits
// RULE20 - Low line at enable starts reception
// RULE21 - Enables synchronised to base clock
// RULE22 - Software changes format only when disabled
// RULE23 - Data shifted least significant bit first
// RULE24 - Bit rate is divider output halved
// RULE25 - Frame: start, data, parity, stops
// RULE26 - Pulse completion events for each direction
`include "usm_map.vh"
module usm_core #(
	parameter SAMPLE_DIV = 16 // Reserved: receive samples per bit slot.
) (
	input  wire        clk,           // System clock, 125 MHz.
	input  wire        resetn,        // Synchronous reset, active low.
	input  wire [15:0] bus_addr,      // Register address.
	input  wire        bus_wr,        // Write strobe.
	input  wire        bus_rd,        // Read strobe.
	input  wire [7:0]  bus_wdata,     // Write data.
	output reg  [7:0]  bus_rdata,     // Read data, registered.
	input  wire        serial_rx_pin, // Receive line from partner.
	output reg         serial_tx_pin, // Transmit line, high when idle.
	output reg         tx_complete_irq, // Transmit done pulse.
	output reg         rx_complete_irq, // Receive done pulse.
	output reg         rx_error_irq     // Receive error pulse.
);
	// ****************************************
	// Registers and state
	// ****************************************
	localparam TX_IDLE = 3'h0; // Line idle.
	localparam TX_START = 3'h1; // Start bit.
	localparam TX_DATA = 3'h2; // Data bits.
	localparam TX_PAR = 3'h3; // Parity bit.
	localparam TX_STOP = 3'h4; // Stop bits.
	localparam RX_IDLE = 2'h0; // Waiting for falling line.
	localparam RX_START = 2'h1; // Checking start bit centre.
	localparam RX_DATA = 2'h2; // Data and parity bits.
	localparam RX_STOP = 2'h3; // Single stop bit.

	reg  [7:0] uart_mode_control_reg; // Mode register.
	reg  [7:0] baud_gen_control_reg;  // Baud control register.
	reg  [7:0] rx_data_buffer_reg;    // Receive buffer.
	reg  [7:0] tx_data_shifter_reg;   // Transmit shift register.
	reg  [2:0] rx_error_status_reg;   // Parity, frame, overrun flags.
	reg        rx_full_reg;           // Buffer holds unread data.
	reg  [1:0] rx_meta_reg;           // Receive pin synchroniser.
	reg        txen_s_reg;            // Transmit enable on base clock.
	reg        rxen_s_reg;            // Receive enable on base clock.
	reg  [2:0] tx_state_reg;          // Transmit state.
	reg  [3:0] tx_cnt_reg;            // Transmit bit counter.
	reg        tx_par_reg;            // Running transmit parity.
	reg        tx_pend_reg;           // Write waiting for a bit edge.
	reg  [1:0] rx_state_reg;          // Receive state.
	reg  [3:0] rx_cnt_reg;            // Receive bit counter.
	reg  [4:0] rx_phase_reg;          // Divider ticks within a bit.
	reg  [8:0] rx_shift_path_reg;     // Receive shift path with parity.
	wire       base_tick;             // Base clock pulse.
	wire       div_tick;              // Divider output pulse.
	wire       bit_tick;              // Line bit rate pulse.
	wire       power_on;              // Power enable bit.
	wire       rx_line;               // Receive line as seen inside.
	wire [1:0] par_mode;              // Parity selection.
	wire [3:0] nbits;                 // Data bits per character.
	wire       rx_par_ok;             // Received parity matches.
	wire       rx_par_bit;            // Parity slot of the received frame.

	assign power_on = uart_mode_control_reg[`USM_MODE_POWER];
	assign par_mode = uart_mode_control_reg[`USM_MODE_PAR_HI:`USM_MODE_PAR_LO];
	assign nbits = uart_mode_control_reg[`USM_MODE_CLEN] ? 4'h8 : 4'h7; // RULE16
	assign rx_line = power_on ? rx_meta_reg[1] : 1'b1; // RULE11

	// Even/odd parity of a 9-bit value under the current length.
	function par_of;
		input [8:0] v;
		input       eight;
		begin
			par_of = eight ? ^v[7:0] : ^v[6:0];
		end
	endfunction

	// Odd mode: data plus parity bit has an odd count of ones.
	// The parity bit lands just above the last data bit, so a seven-bit
	// frame keeps it one place lower than an eight-bit frame does.
	assign rx_par_bit = nbits[3] ? rx_shift_path_reg[8] : rx_shift_path_reg[7];
	assign rx_par_ok = (par_mode == `USM_PAR_ODD) ?
		(par_of(rx_shift_path_reg, nbits[3]) != rx_par_bit) :
		(par_of(rx_shift_path_reg, nbits[3]) == rx_par_bit); // RULE14

	usm_baud_gen u_baud (
		.clk       (clk),
		.resetn    (resetn),
		.run       (power_on),
		.baud_cfg  (baud_gen_control_reg),
		.base_tick (base_tick),
		.div_tick  (div_tick),
		.half_tick (bit_tick)
	);

	// ****************************************
	// Bus registers
	// ****************************************
	// Writes, reads and synchronisers; power off clears the data side.
	always @(posedge clk) begin
		rx_meta_reg <= {rx_meta_reg[0], serial_rx_pin};
		if (!resetn) begin
			uart_mode_control_reg <= `USM_MODE_RESET; // RULE9
			baud_gen_control_reg  <= `USM_BAUD_RESET;
			bus_rdata             <= 8'h00;
			rx_meta_reg           <= 2'h3;
			txen_s_reg            <= 1'b0;
			rxen_s_reg            <= 1'b0;
		end else begin
			if (bus_wr && bus_addr == `USM_ADDR_MODE)
				uart_mode_control_reg <= bus_wdata; // RULE9
			if (bus_wr && bus_addr == `USM_ADDR_BAUD)
				baud_gen_control_reg <= bus_wdata;
			// Enables follow the register on base clock edges; power off clears them at once.
			if (!power_on) begin
				txen_s_reg <= 1'b0;
				rxen_s_reg <= 1'b0;
			end else if (base_tick) begin
				txen_s_reg <= uart_mode_control_reg[`USM_MODE_TXEN]; // RULE21
				rxen_s_reg <= uart_mode_control_reg[`USM_MODE_RXEN]; // RULE21
			end
			// The transmit shifter is write-only and reads as zero.
			if (bus_rd) begin
				case (bus_addr)
				`USM_ADDR_MODE:  bus_rdata <= uart_mode_control_reg;
				`USM_ADDR_BAUD:  bus_rdata <= baud_gen_control_reg;
				// Power off acts at once, as the buffer's own
				// clear only lands one edge after the mode write.
				`USM_ADDR_RXBUF: bus_rdata <= power_on ?
					rx_data_buffer_reg : `USM_DATA_RESET; // RULE4 RULE10
				`USM_ADDR_ERR:   bus_rdata <= {5'h00, rx_error_status_reg};
				default:         bus_rdata <= 8'h00; // RULE5
				endcase
			end
		end
	end

	// ****************************************
	// Transmitter
	// ****************************************
	// A write is held pending until the next bit edge, then framed.
	always @(posedge clk) begin
		tx_complete_irq <= 1'b0;
		if (!resetn || !power_on || !txen_s_reg) begin // RULE12
			tx_data_shifter_reg <= `USM_DATA_RESET; // RULE6
			tx_state_reg        <= TX_IDLE;
			tx_cnt_reg          <= 4'h0;
			tx_par_reg          <= 1'b0;
			tx_pend_reg         <= 1'b0;
			serial_tx_pin       <= 1'b1;
		end else begin
			if (bus_wr && bus_addr == `USM_ADDR_TXSHIFT) begin
				tx_data_shifter_reg <= bus_wdata; // RULE5
				tx_pend_reg         <= 1'b1;
			end
			if (bit_tick) begin
				case (tx_state_reg)
				TX_IDLE: begin
					serial_tx_pin <= 1'b1;
					if (tx_pend_reg) begin
						tx_pend_reg   <= 1'b0;
						tx_par_reg    <= par_of({1'b0, tx_data_shifter_reg},
							nbits[3]);
						serial_tx_pin <= 1'b0; // RULE25
						tx_state_reg  <= TX_START;
					end
				end
				TX_START, TX_DATA: begin
					serial_tx_pin <= tx_data_shifter_reg[tx_cnt_reg[2:0]]; // RULE23
					tx_cnt_reg    <= tx_cnt_reg + 4'h1;
					tx_state_reg  <= TX_DATA;
					if (tx_cnt_reg == nbits) begin
						tx_cnt_reg <= 4'h0;
						// RULE14
						case (par_mode)
						`USM_PAR_NONE: begin
							serial_tx_pin <= 1'b1;
							tx_state_reg  <= TX_STOP;
						end
						`USM_PAR_ZERO: begin
							serial_tx_pin <= 1'b0;
							tx_state_reg  <= TX_PAR;
						end
						`USM_PAR_ODD: begin
							serial_tx_pin <= ~tx_par_reg;
							tx_state_reg  <= TX_PAR;
						end
						default: begin
							serial_tx_pin <= tx_par_reg;
							tx_state_reg  <= TX_PAR;
						end
						endcase
					end
				end
				TX_PAR: begin
					serial_tx_pin <= 1'b1;
					tx_state_reg  <= TX_STOP;
				end
				TX_STOP: begin
					// Second stop slot only when two stops are selected.
					if (uart_mode_control_reg[`USM_MODE_STOP] &&
						tx_cnt_reg == 4'h0) begin // RULE17
						tx_cnt_reg <= 4'h1;
					end else begin
						tx_cnt_reg      <= 4'h0;
						tx_state_reg    <= TX_IDLE;
						tx_complete_irq <= 1'b1; // RULE26
					end
				end
				default: tx_state_reg <= TX_IDLE;
				endcase
			end
		end
	end

	// ****************************************
	// Receiver
	// ****************************************
	// Samples on divider ticks; a bit is two ticks, so the centre is
	// the second tick. Coarse, but it needs no extra oversampling clock.
	always @(posedge clk) begin
		rx_complete_irq <= 1'b0;
		rx_error_irq    <= 1'b0;
		if (!resetn || !power_on) begin // RULE10
			rx_data_buffer_reg  <= `USM_DATA_RESET; // RULE4
			rx_error_status_reg <= 3'h0;
			rx_full_reg         <= 1'b0;
		end else begin
			// Reading the status clears it; reading the buffer frees it.
			if (bus_rd && bus_addr == `USM_ADDR_ERR)
				rx_error_status_reg <= 3'h0;
			if (bus_rd && bus_addr == `USM_ADDR_RXBUF)
				rx_full_reg <= 1'b0;
			if (!rxen_s_reg)
				rx_error_status_reg <= 3'h0;
			// A completed frame sets flags after the clears above.
			if (rxen_s_reg && div_tick && rx_state_reg == RX_STOP &&
				rx_phase_reg[0]) begin
				if (rx_full_reg) begin
					rx_error_status_reg[`USM_ERR_OVERRUN] <= 1'b1; // RULE3
				end else begin
					rx_full_reg <= 1'b1;
					// RULE1
					rx_data_buffer_reg <= nbits[3] ? rx_shift_path_reg[7:0] :
						{1'b0, rx_shift_path_reg[6:0]}; // RULE2
					rx_complete_irq <= 1'b1; // RULE26
				end
				if (!rx_line)
					rx_error_status_reg[`USM_ERR_FRAME] <= 1'b1; // RULE18
				if (par_mode[1] && !rx_par_ok)
					rx_error_status_reg[`USM_ERR_PARITY] <= 1'b1; // RULE15
				if (rx_full_reg || !rx_line || (par_mode[1] && !rx_par_ok))
					rx_error_irq <= 1'b1;
			end
		end
	end

	// Receive sequencer; cleared whenever reception is disabled.
	always @(posedge clk) begin
		if (!resetn || !rxen_s_reg) begin // RULE13
			rx_state_reg      <= RX_IDLE;
			rx_cnt_reg        <= 4'h0;
			rx_phase_reg      <= 5'h00;
			rx_shift_path_reg <= 9'h000;
		end else if (div_tick) begin
			rx_phase_reg <= rx_phase_reg + 5'h01;
			case (rx_state_reg)
			RX_IDLE: begin
				rx_phase_reg <= 5'h00;
				if (!rx_line)
					rx_state_reg <= RX_START; // RULE20
			end
			RX_START: begin
				rx_phase_reg <= 5'h00;
				rx_cnt_reg   <= 4'h0;
				rx_state_reg <= rx_line ? RX_IDLE : RX_DATA;
			end
			RX_DATA: begin
				if (rx_phase_reg[0]) begin
					// RULE23
					rx_shift_path_reg[rx_cnt_reg] <= rx_line;
					rx_cnt_reg <= rx_cnt_reg + 4'h1;
					if (rx_cnt_reg == nbits - {3'h0, par_mode == 2'h0})
						rx_state_reg <= RX_STOP;
				end
			end
			RX_STOP: begin
				if (rx_phase_reg[0])
					rx_state_reg <= RX_IDLE;
			end
			default: rx_state_reg <= RX_IDLE;
			endcase
		end
	end
endmodule // usm_core

//--- verif/usm_core_chk.sv
`timescale 1ns/1ps
`include "usm_map.vh"
// ****************************************
// Port checker for the serial core
// ****************************************
module usm_core_chk (
	input wire        clk,             // System clock.
	input wire        resetn,          // Synchronous reset, active low.
	input wire [15:0] bus_addr,        // Register address.
	input wire        bus_wr,          // Write strobe.
	input wire        bus_rd,          // Read strobe.
	input wire [7:0]  bus_wdata,       // Write data.
	input wire [7:0]  bus_rdata,       // Read data.
	input wire        serial_tx_pin,   // Transmit line.
	input wire        tx_complete_irq, // Transmit done pulse.
	input wire        rx_complete_irq, // Receive done pulse.
	input wire        rx_error_irq     // Receive error pulse.
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (!resetn);
	// Power off directly followed by a buffer read.
	sequence s_off_read;
		bus_wr && bus_addr == `USM_ADDR_MODE && !bus_wdata[7]
		##1 bus_rd && bus_addr == `USM_ADDR_RXBUF;
	endsequence
	property p_tx_rd;
		bus_rd && bus_addr == `USM_ADDR_TXSHIFT |=> bus_rdata == 8'h00;
	endproperty
	a_tx_rd: assert property (p_tx_rd)
		else $error("tx shifter read is not zero");
	property p_rst_mode;
		resetn && !$past(resetn) && bus_rd && bus_addr == `USM_ADDR_MODE
		|=> bus_rdata == 8'h01;
	endproperty
	a_rst_mode: assert property (p_rst_mode)
		else $error("mode register not 01 after reset");
	property p_off_buf;
		s_off_read |=> bus_rdata == 8'hFF;
	endproperty
	a_off_buf: assert property (p_off_buf)
		else $error("buffer not all ones after power off");
	property p_tx_pulse;
		tx_complete_irq |=> !tx_complete_irq;
	endproperty
	a_tx_pulse: assert property (p_tx_pulse)
		else $error("transmit done longer than a cycle");
	property p_rx_pulse;
		rx_complete_irq |=> !rx_complete_irq;
	endproperty
	a_rx_pulse: assert property (p_rx_pulse)
		else $error("receive done longer than a cycle");
	property p_err_pulse;
		rx_error_irq |=> !rx_error_irq;
	endproperty
	a_err_pulse: assert property (p_err_pulse)
		else $error("error pulse longer than a cycle");
	// The shortest legal bit slot is far longer than eight cycles.
	property p_start;
		$fell(serial_tx_pin) |-> !serial_tx_pin [*8];
	endproperty
	a_start: assert property (p_start)
		else $error("start bit too short");
	property p_stop;
		tx_complete_irq |-> serial_tx_pin;
	endproperty
	a_stop: assert property (p_stop)
		else $error("line not high at transmit done");
	// Slack covers the slowest base clock the enable waits for.
	property p_tx_off;
		bus_wr && bus_addr == `USM_ADDR_MODE && !bus_wdata[6]
		|-> ##[1:70] serial_tx_pin;
	endproperty
	a_tx_off: assert property (p_tx_off)
		else $error("line not idle after transmit disable");
	c_tx: cover property (tx_complete_irq);
	c_rx: cover property (rx_complete_irq);
	c_err: cover property (rx_error_irq);
	c_off: cover property (s_off_read);
endmodule // usm_core_chk
bind usm_core usm_core_chk u_chk (.clk(clk), .resetn(resetn),
	.bus_addr(bus_addr), .bus_wr(bus_wr), .bus_rd(bus_rd),
	.bus_wdata(bus_wdata), .bus_rdata(bus_rdata),
	.serial_tx_pin(serial_tx_pin), .tx_complete_irq(tx_complete_irq),
	.rx_complete_irq(rx_complete_irq), .rx_error_irq(rx_error_irq));

//--- verif/usm_peer.sv
`timescale 1ns/1ps
// ****************************************
// Remote serial partner on the two data lines
// ****************************************
module usm_peer #(
	parameter BIT = 32 // Clocks per bit slot.
) (
	input  wire clk,     // Bench clock.
	input  wire line_in, // Transmit line of the core.
	output reg  line_out // Receive line of the core.
);
	reg [10:0] slots_q [$]; // Slots captured after each start bit.
	reg [10:0] cap;         // Slots of the frame in progress.
	integer    i;           // Slot index.
	initial line_out = 1'b1; // Idle mark level.
	// Sample each slot mid-bit, LSB first; eleven slots hold any frame.
	always begin
		@(negedge line_in);
		repeat (BIT / 2) @(posedge clk);
		if (line_in === 1'b0) begin
			for (i = 0; i < 11; i = i + 1) begin
				repeat (BIT) @(posedge clk);
				cap[i] = line_in;
			end
			slots_q.push_back(cap);
		end
	end
	// Send start, then n slots LSB first; the last is the stop bit.
	task send(input [10:0] bits, input integer n);
		integer k;
		begin
			@(posedge clk) line_out <= 1'b0;
			for (k = 0; k < n; k = k + 1) begin
				repeat (BIT) @(posedge clk);
				line_out <= bits[k];
			end
			repeat (BIT) @(posedge clk);
		end
	endtask
endmodule // usm_peer

//--- verif/tb.sv
`timescale 1ns/1ps
`include "usm_map.vh"
// ****************************************
// Self-checking bench for the serial core
// ****************************************
module tb;
	localparam BIT = 32; // Baud code 08: 2 * 8 * 2 clocks per bit.
	localparam [11:0] PARS = {2'h3, 2'h3, 2'h0, 2'h1, 2'h2, 2'h2};
	localparam [5:0]  CLS  = 6'b100111; // Length per receive case.
	localparam [5:0]  FLS  = 6'b100110; // Parity flip per receive case.
	reg         clk, resetn, bus_wr, bus_rd; // Clock, reset, strobes.
	reg  [15:0] bus_addr;                    // Register address.
	reg  [7:0]  bus_wdata, got, d, e_st;     // Bus data and expectations.
	reg  [1:0]  pm;                          // Parity mode in use.
	reg         cl, fl;                      // Length bit and flip.
	wire [7:0]  bus_rdata;                   // Read data.
	wire        rx_pin, tx_pin, tx_irq, rx_irq, err_irq; // Core pins.
	integer     num_errors = 0, checks = 0;  // Verdict counters.
	integer     err_seen = 0, rx_seen = 0, tx_seen = 0; // Pulse counts.
	integer     i, j, t, e, r, n;            // Loop and timing scratch.
	usm_core uut (.clk(clk), .resetn(resetn), .bus_addr(bus_addr),
		.bus_wr(bus_wr), .bus_rd(bus_rd), .bus_wdata(bus_wdata),
		.bus_rdata(bus_rdata), .serial_rx_pin(rx_pin),
		.serial_tx_pin(tx_pin), .tx_complete_irq(tx_irq),
		.rx_complete_irq(rx_irq), .rx_error_irq(err_irq));
	usm_peer #(.BIT(BIT)) peer (.clk(clk), .line_in(tx_pin),
		.line_out(rx_pin));
	initial begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end
	// Pulses are counted so a missing or extra one shows up.
	always @(posedge clk) begin
		err_seen <= err_seen + (err_irq === 1'b1);
		rx_seen <= rx_seen + (rx_irq === 1'b1);
		tx_seen <= tx_seen + (tx_irq === 1'b1);
	end
	task check(input [15:0] seen, input [15:0] want, input [8*8:1] what);
		begin
			checks = checks + 1;
			if (seen !== want) begin
				num_errors = num_errors + 1;
				$display("[ERR] %0s exp %0h seen %0h", what, want, seen);
			end
		end
	endtask
	task wr(input [15:0] a, input [7:0] v);
		begin
			bus_addr <= a;
			bus_wdata <= v;
			bus_wr <= 1'b1;
			@(posedge clk) bus_wr <= 1'b0;
		end
	endtask
	// Read data is registered, so it is taken a half cycle later.
	task rd(input [15:0] a);
		begin
			bus_addr <= a;
			bus_rd <= 1'b1;
			@(posedge clk) bus_rd <= 1'b0;
			@(negedge clk) got = bus_rdata;
			@(posedge clk);
		end
	endtask
	// Disable both ways before a format change, then wait two base clocks.
	task setm(input [7:0] m);
		begin
			wr(`USM_ADDR_MODE, 8'h81);
			repeat (4) @(posedge clk);
			wr(`USM_ADDR_MODE, m);
			repeat (4) @(posedge clk);
		end
	endtask
	// Model of one frame: data LSB first, parity, then mark slots.
	function [10:0] frame(input [7:0] dv, input eight, input [1:0] pmv,
		input flip);
		reg p;
		integer k;
		begin
			p = ^(dv & (eight ? 8'hFF : 8'h7F));
			frame = 11'h7FF;
			for (k = 0; k < (eight ? 8 : 7); k = k + 1)
				frame[k] = dv[k];
			if (pmv != 2'h0)
				frame[eight ? 8 : 7] = flip ^ ((pmv == 2'h1) ? 1'b0 :
					(pmv == 2'h2) ? ~p : p);
		end
	endfunction
	task rxf(input [7:0] dv, input [1:0] pmv, input eight, input flip);
		begin
			peer.send(frame(dv, eight, pmv, flip),
				(eight ? 9 : 8) + (pmv != 2'h0));
			repeat (BIT) @(posedge clk);
		end
	endtask
	task test_done;
		begin
			if (num_errors == 0 && checks > 0)
				$display("SIMULATION PASSED");
			else
				$display("SIMULATION FAILED");
			$finish;
		end
	endtask
	initial begin
		resetn = 1'b0;
		{bus_wr, bus_rd, bus_addr, bus_wdata} = 26'h0;
		i = $urandom(24);
		repeat (2) @(posedge clk);
		resetn <= 1'b1;
		rd(`USM_ADDR_MODE);
		check(got, 8'h01, "mode");
		rd(`USM_ADDR_RXBUF);
		check(got, 8'hFF, "rxbuf");
		rd(`USM_ADDR_TXSHIFT);
		check(got, 8'h00, "txread");
		rd(16'hFF7F);
		check(got, 8'h00, "unmapped");
		wr(`USM_ADDR_BAUD, 8'h08);
		wr(`USM_ADDR_MODE, 8'h9B);
		rd(`USM_ADDR_MODE);
		check(got, 8'h9B, "modewr");
		// Every parity mode, both lengths, both stop counts on the wire.
		for (i = 0; i < 8; i = i + 1) begin
			setm({3'b110, i[1:0], i[2], i[0], 1'b1});
			d = $urandom;
			wr(`USM_ADDR_TXSHIFT, d);
			n = (BIT * (2 + (i[2] ? 8 : 7) + (i[1:0] != 0) + i[0]));
			t = 0;
			while (tx_pin !== 1'b0 && t < 400) begin
				@(negedge clk);
				t = t + 1;
			end
			t = 0;
			while (tx_irq !== 1'b1 && t < 600) begin
				@(negedge clk);
				t = t + 1;
			end
			check(t >= n - 1 && t <= n + 1, 1, "txlen");
			while (peer.slots_q.size() == 0 && t < 1200) begin
				@(posedge clk);
				t = t + 1;
			end
			check(peer.slots_q.pop_front(), frame(d, i[2], i[1:0], 1'b0),
				"txframe");
		end
		// Receive cases: good and bad parity, zero parity, seven bits.
		for (j = 0; j < 6; j = j + 1) begin
			pm = PARS >> (2 * j);
			cl = CLS[j];
			fl = FLS[j];
			setm({3'b101, pm, cl, 2'b01});
			d = $urandom;
			e = err_seen;
			r = rx_seen;
			rxf(d, pm, cl, fl);
			e_st = (pm[1] && fl) ? 8'h04 : 8'h00;
			rd(`USM_ADDR_ERR);
			check(got, e_st, "status");
			rd(`USM_ADDR_RXBUF);
			check(got, cl ? d : {1'b0, d[6:0]}, "rxdata");
			check(err_seen - e, e_st != 0, "errirq");
			check(rx_seen - r, 1, "rxirq");
		end
		// Second character arrives before the first is read.
		d = $urandom;
		rxf(d, 2'h3, 1'b1, 1'b0);
		rxf(~d, 2'h3, 1'b1, 1'b0);
		rd(`USM_ADDR_ERR);
		check(got, 8'h01, "overrun");
		rd(`USM_ADDR_RXBUF);
		check(got, d, "keep");
		// A write while powered must leave the held character alone.
		wr(`USM_ADDR_RXBUF, ~d);
		rd(`USM_ADDR_RXBUF);
		check(got, d, "robuf");
		wr(`USM_ADDR_MODE, 8'h81);
		repeat (4) @(posedge clk);
		wr(`USM_ADDR_MODE, 8'h01);
		rd(`USM_ADDR_RXBUF);
		check(got, 8'hFF, "offbuf");
		// Transmit disabled in mid-frame: line idles, no done pulse.
		setm(8'hC5);
		wr(`USM_ADDR_TXSHIFT, 8'h00);
		r = tx_seen;
		repeat (3 * BIT) @(posedge clk);
		wr(`USM_ADDR_MODE, 8'h85);
		repeat (8) @(posedge clk);
		check(tx_pin, 1, "txoff");
		repeat (12 * BIT) @(posedge clk);
		check(tx_seen - r, 0, "noirq");
		test_done;
	end
	initial begin
		repeat (40000) @(posedge clk);
		num_errors = num_errors + 1;
		test_done;
	end
endmodule // tb
